// [hpc_map.vh]
// constants for the hub port power and strap block: register offsets,
// reset values, field positions and timing counts.
// assumes a single 10 MHz device clock; included by the top module only, not by the synchroniser.
//
// Functional notes
// - indicator polarity follows latched strap hi bit
// - indicator asserted at high speed, negated otherwise
// - port 1 power pin high enables power
// - port 2 power pin high enables power
// - port 1 combined pin: open-drain enable, overcurrent sense
// - port 2 combined pin: open-drain enable, overcurrent sense
// - port 1 charging strap one means supported
// - port 2 charging strap one means supported
// - both method straps together pick configuration method
// - straps latch after every reset release
// - self power sampled in configuration state
// - self power frozen unless dynamic switching enabled
// - dynamic switching only when register holds 0x41
// - dynamic register written by smbus or otp
// - fixed device state from register when detect used
// - self power level one means local supply
`ifndef HPC_MAP_VH
`define HPC_MAP_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define HPC_DYN_PWR_ADDR 16'h4134
`define HPC_FIXED_DEV_ADDR 16'h4135
`define HPC_DYN_PWR_RESET 8'hC1
`define HPC_DYN_PWR_ENABLE 8'h41
`define HPC_FIXED_DEV_RESET 2'b00
`define HPC_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// field positions of the synchronised strap and sense pin vector
// ----------------------------------------------------------------
`define HPC_SYNC_W 11
`define HPC_BIT_SEL_HI 0
`define HPC_BIT_SEL_LO 1
`define HPC_BIT_CHG1 2
`define HPC_BIT_CHG2 3
`define HPC_BIT_FIX0 4
`define HPC_BIT_FIX1 5
`define HPC_BIT_SELF 6
`define HPC_BIT_OC1 7
`define HPC_BIT_OC2 8
`define HPC_BIT_CTL1 9
`define HPC_BIT_CTL2 10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HPC_CLK_PERIOD_NS 100
`define HPC_SETTLE_NS 1000
`define HPC_OC_BLANK_NS 1000
`define HPC_SETTLE_CYC ((`HPC_SETTLE_NS + `HPC_CLK_PERIOD_NS - 1) / `HPC_CLK_PERIOD_NS)
`define HPC_OC_BLANK_CYC ((`HPC_OC_BLANK_NS + `HPC_CLK_PERIOD_NS - 1) / `HPC_CLK_PERIOD_NS)

`endif

// [hpc_sync.v]
// two flip-flop synchroniser for the strap and sense pins.
// assumes inputs are asynchronous to mclk_in; resets to all zeros.
`timescale 1ns/100ps

module hpc_sync #(
   parameter WIDTH = 11
) (
   input wire mclk_in,
   input wire rst_n_in,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;

   // stage1 feeds only stage2
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage1_reg <= {WIDTH{1'b0}};
         stage2_reg <= {WIDTH{1'b0}};
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_out = stage2_reg;

endmodule

// [hpc_top.v]
// pin-level power and strap logic of a two-port hub: speed indicator,
// port power enables, combined open-drain control pins, strap latches,
// self power detect and the dynamic power register.
// assumes hub core signals and register/otp ports are on mclk_in;
// straps, sense pins and control pin inputs are asynchronous pins.
`timescale 1ns/100ps
`include "hpc_map.vh"

module hpc_top (
   input wire mclk_in,
   input wire rst_n_in,
   // straps and sense pins
   input wire config_method_strap_hi_in,
   input wire config_method_strap_lo_in,
   input wire port1_charging_strap_in,
   input wire port2_charging_strap_in,
   input wire [1:0] fixed_device_straps_in,
   input wire self_power_detect_in,
   input wire port1_overcurrent_low_in,
   input wire port2_overcurrent_low_in,
   // combined control pins
   input wire port1_combined_control_pin_in,
   output wire port1_combined_control_pin_out,
   output wire port1_combined_control_pin_oe_n_out,
   input wire port2_combined_control_pin_in,
   output wire port2_combined_control_pin_out,
   output wire port2_combined_control_pin_oe_n_out,
   // hub core side
   input wire upstream_connected_in,
   input wire upstream_high_speed_in,
   input wire combined_control_mode_in,
   input wire self_power_function_in,
   input wire port1_power_request_in,
   input wire port2_power_request_in,
   // smbus register port
   input wire reg_write_in,
   input wire reg_read_in,
   input wire [15:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   output wire [7:0] reg_rdata_out,
   // otp load of the dynamic power register
   input wire otp_load_in,
   input wire [7:0] otp_data_in,
   // outputs
   output wire upstream_speed_indicator_out,
   output wire port1_power_enable_out,
   output wire port2_power_enable_out,
   output wire port1_overcurrent_out,
   output wire port2_overcurrent_out,
   output wire port1_charging_enable_out,
   output wire port2_charging_enable_out,
   output wire [1:0] config_method_out,
   output wire self_powered_out,
   output wire [1:0] fixed_device_out,
   output wire config_done_out
);

   // ----------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------
   localparam ST_SETTLE = 2'd0;
   localparam ST_CONFIG = 2'd1;
   localparam ST_RUN = 2'd2;

   localparam integer SETTLE_CYC = `HPC_SETTLE_CYC;
   localparam integer BLANK_CYC = `HPC_OC_BLANK_CYC;
   localparam [3:0] SETTLE_LAST = SETTLE_CYC[3:0] - 4'h1;
   localparam [3:0] BLANK_LAST = BLANK_CYC[3:0];

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // overcurrent sense level for one port; in combined mode the pin
   // itself is read, and only while released, since driving it low
   // would read back as a false fault
   function sense_fault;
      input combined;
      input pin_level;
      input dedicated_level;
      begin
         if (combined) begin
            sense_fault = ~pin_level;
         end else begin
            sense_fault = ~dedicated_level;
         end
      end
   endfunction

   // blanking counter step, saturating at the blank length
   function [3:0] blank_step;
      input powered;
      input [3:0] count;
      begin
         if (!powered) begin
            blank_step = 4'h0;
         end else if (count != BLANK_LAST) begin
            blank_step = count + 4'h1;
         end else begin
            blank_step = count;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   wire [`HPC_SYNC_W-1:0] pins_raw;
   wire [`HPC_SYNC_W-1:0] pins_s;

   assign pins_raw = {port2_combined_control_pin_in,
                      port1_combined_control_pin_in,
                      port2_overcurrent_low_in,
                      port1_overcurrent_low_in,
                      self_power_detect_in,
                      fixed_device_straps_in[1],
                      fixed_device_straps_in[0],
                      port2_charging_strap_in,
                      port1_charging_strap_in,
                      config_method_strap_lo_in,
                      config_method_strap_hi_in};

   hpc_sync #(
      .WIDTH(`HPC_SYNC_W)
   ) u_sync (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   // ----------------------------------------------------------------
   // configuration sequence after reset release
   // ----------------------------------------------------------------
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [3:0] settle_cnt_reg;
   reg [3:0] settle_cnt_next;

   always @* begin
      state_next = state_reg;
      settle_cnt_next = settle_cnt_reg;
      case (state_reg)
         ST_SETTLE: begin
            // wait for the synchronised straps to be stable
            if (settle_cnt_reg == SETTLE_LAST) begin
               state_next = ST_CONFIG;
            end else begin
               settle_cnt_next = settle_cnt_reg + 4'h1;
            end
         end
         ST_CONFIG: begin
            state_next = ST_RUN;
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_SETTLE;
            settle_cnt_next = 4'h0;
         end
      endcase
   end

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= ST_SETTLE;
         settle_cnt_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         settle_cnt_reg <= settle_cnt_next;
      end
   end

   wire in_config = (state_reg == ST_CONFIG);
   wire in_run = (state_reg == ST_RUN);

   // ----------------------------------------------------------------
   // strap latches
   // ----------------------------------------------------------------
   // one reset input serves both power-on and external reset, so each
   // release walks through the configuration state again
   reg sel_hi_reg;
   reg sel_lo_reg;
   reg chg1_reg;
   reg chg2_reg;
   reg [1:0] fix_strap_reg;

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_hi_reg <= 1'b0;
         sel_lo_reg <= 1'b0;
         chg1_reg <= 1'b0;
         chg2_reg <= 1'b0;
         fix_strap_reg <= 2'b00;
      end else if (in_config) begin
         sel_hi_reg <= pins_s[`HPC_BIT_SEL_HI];
         sel_lo_reg <= pins_s[`HPC_BIT_SEL_LO];
         chg1_reg <= pins_s[`HPC_BIT_CHG1];
         chg2_reg <= pins_s[`HPC_BIT_CHG2];
         fix_strap_reg <= {pins_s[`HPC_BIT_FIX1], pins_s[`HPC_BIT_FIX0]};
      end
   end

   assign config_method_out = {sel_hi_reg, sel_lo_reg};
   assign port1_charging_enable_out = chg1_reg;
   assign port2_charging_enable_out = chg2_reg;
   assign config_done_out = in_run;

   // ----------------------------------------------------------------
   // registers: dynamic power and fixed device state
   // ----------------------------------------------------------------
   // an otp load locks the value; later smbus writes are ignored
   reg [7:0] dyn_pwr_reg;
   reg otp_lock_reg;
   reg [1:0] fixed_dev_reg;
   reg [7:0] rdata_reg;

   wire wr_dyn = reg_write_in & (reg_addr_in == `HPC_DYN_PWR_ADDR);
   wire wr_fix = reg_write_in & (reg_addr_in == `HPC_FIXED_DEV_ADDR);

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dyn_pwr_reg <= `HPC_DYN_PWR_RESET;
         otp_lock_reg <= 1'b0;
         fixed_dev_reg <= `HPC_FIXED_DEV_RESET;
      end else begin
         if (otp_load_in) begin
            dyn_pwr_reg <= otp_data_in;
            otp_lock_reg <= 1'b1;
         end else if (wr_dyn && !otp_lock_reg) begin
            dyn_pwr_reg <= reg_wdata_in;
         end
         if (wr_fix) begin
            fixed_dev_reg <= reg_wdata_in[1:0];
         end
      end
   end

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_reg <= `HPC_UNMAPPED_READ;
      end else if (reg_read_in) begin
         if (reg_addr_in == `HPC_DYN_PWR_ADDR) begin
            rdata_reg <= dyn_pwr_reg;
         end else if (reg_addr_in == `HPC_FIXED_DEV_ADDR) begin
            rdata_reg <= {6'b00_0000, fixed_dev_reg};
         end else begin
            rdata_reg <= `HPC_UNMAPPED_READ;
         end
      end
   end

   assign reg_rdata_out = rdata_reg;

   wire dyn_enable = (dyn_pwr_reg == `HPC_DYN_PWR_ENABLE);

   // strap pins are ignored when the detect function shares them
   assign fixed_device_out = self_power_function_in ? fixed_dev_reg : fix_strap_reg;

   // ----------------------------------------------------------------
   // self power detect
   // ----------------------------------------------------------------
   reg self_pwr_reg;

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         self_pwr_reg <= 1'b0;
      end else if (in_config) begin
         self_pwr_reg <= pins_s[`HPC_BIT_SELF];
      end else if (in_run && dyn_enable) begin
         self_pwr_reg <= pins_s[`HPC_BIT_SELF];
      end
   end

   // one means a local supply, zero means bus powered
   assign self_powered_out = self_pwr_reg;

   // ----------------------------------------------------------------
   // upstream speed indicator
   // ----------------------------------------------------------------
   reg spd_ind_reg;
   wire spd_asserted = in_run & upstream_connected_in & upstream_high_speed_in;

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         spd_ind_reg <= 1'b0;
      end else begin
         spd_ind_reg <= spd_asserted ^ sel_hi_reg;
      end
   end

   assign upstream_speed_indicator_out = spd_ind_reg;

   // ----------------------------------------------------------------
   // port power and overcurrent
   // ----------------------------------------------------------------
   // sensing is blanked after power-on so inrush and the slow rise of
   // the pulled-up combined pin are not taken as a fault
   reg pwr1_on_reg;
   reg pwr2_on_reg;
   reg oc1_reg;
   reg oc2_reg;
   reg [3:0] blank1_reg;
   reg [3:0] blank2_reg;
   reg pin1_reg;
   reg pin2_reg;
   reg ctl1_oe_n_reg;
   reg ctl2_oe_n_reg;

   wire oc1_event = in_run & pwr1_on_reg & (blank1_reg == BLANK_LAST) &
                    sense_fault(combined_control_mode_in, pins_s[`HPC_BIT_CTL1], pins_s[`HPC_BIT_OC1]);
   wire oc2_event = in_run & pwr2_on_reg & (blank2_reg == BLANK_LAST) &
                    sense_fault(combined_control_mode_in, pins_s[`HPC_BIT_CTL2], pins_s[`HPC_BIT_OC2]);

   // a fault holds until the core drops the request; a new fault wins
   wire oc1_next = oc1_event | (oc1_reg & port1_power_request_in);
   wire oc2_next = oc2_event | (oc2_reg & port2_power_request_in);
   wire pwr1_next = in_run & port1_power_request_in & ~oc1_next;
   wire pwr2_next = in_run & port2_power_request_in & ~oc2_next;

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pwr1_on_reg <= 1'b0;
         pwr2_on_reg <= 1'b0;
         oc1_reg <= 1'b0;
         oc2_reg <= 1'b0;
         blank1_reg <= 4'h0;
         blank2_reg <= 4'h0;
         pin1_reg <= 1'b0;
         pin2_reg <= 1'b0;
         ctl1_oe_n_reg <= 1'b1;
         ctl2_oe_n_reg <= 1'b1;
      end else begin
         pwr1_on_reg <= pwr1_next;
         pwr2_on_reg <= pwr2_next;
         oc1_reg <= oc1_next;
         oc2_reg <= oc2_next;
         blank1_reg <= blank_step(pwr1_next, blank1_reg);
         blank2_reg <= blank_step(pwr2_next, blank2_reg);
         // dedicated pin drives high for power on, low for off
         pin1_reg <= pwr1_next & ~combined_control_mode_in;
         pin2_reg <= pwr2_next & ~combined_control_mode_in;
         // combined pin: pull low to disable, release to enable
         ctl1_oe_n_reg <= ~(combined_control_mode_in & ~pwr1_next);
         ctl2_oe_n_reg <= ~(combined_control_mode_in & ~pwr2_next);
      end
   end

   assign port1_power_enable_out = pin1_reg;
   assign port2_power_enable_out = pin2_reg;
   assign port1_combined_control_pin_out = 1'b0;
   assign port2_combined_control_pin_out = 1'b0;
   assign port1_combined_control_pin_oe_n_out = ctl1_oe_n_reg;
   assign port2_combined_control_pin_oe_n_out = ctl2_oe_n_reg;
   assign port1_overcurrent_out = oc1_reg;
   assign port2_overcurrent_out = oc2_reg;

endmodule

// [hpc_power_partner.sv]
// board model of the port power switches and current monitors.
// assumes fault_in is commanded by the bench; pins have pull-ups.
`timescale 1ns/100ps

module hpc_power_partner (
   input wire combined_in,
   input wire [1:0] fault_in,
   input wire [1:0] enable_in,
   input wire [1:0] pin_data_in,
   input wire [1:0] pin_oe_n_in,
   output wire [1:0] overcurrent_low_out,
   output wire [1:0] pin_level_out
);
   // ----------------------------------------
   // monitors only flag a port whose switch is on
   // ----------------------------------------
   assign overcurrent_low_out = ~(fault_in & enable_in & {2{~combined_in}});
   // released pin rests high on its pull-up unless the monitor pulls it
   assign pin_level_out = ~((~pin_oe_n_in & ~pin_data_in) | (fault_in & pin_oe_n_in & {2{combined_in}}));
endmodule

// [hpc_chk_sva.sv]
// checker for the port power and strap block, bound to hpc_top.
// assumes one clock domain and reset active low.
`timescale 1ns/100ps

module hpc_chk (
   input wire mclk_in,
   input wire rst_n_in,
   input wire port1_overcurrent_low_in,
   input wire port1_combined_control_pin_in,
   input wire port1_combined_control_pin_out,
   input wire port1_combined_control_pin_oe_n_out,
   input wire port2_combined_control_pin_oe_n_out,
   input wire upstream_connected_in,
   input wire upstream_high_speed_in,
   input wire combined_control_mode_in,
   input wire port1_power_request_in,
   input wire port2_power_request_in,
   input wire reg_write_in,
   input wire reg_read_in,
   input wire [15:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire [7:0] reg_rdata_out,
   input wire otp_load_in,
   input wire upstream_speed_indicator_out,
   input wire port1_power_enable_out,
   input wire port2_power_enable_out,
   input wire port1_overcurrent_out,
   input wire [1:0] config_method_out,
   input wire port1_charging_enable_out,
   input wire config_done_out
);
   logic otp_seen_reg;
   logic [3:0] rel_cnt_reg;
   wire fault1 = !port1_overcurrent_low_in || (!port1_combined_control_pin_in && port1_combined_control_pin_oe_n_out);
   wire wr_dyn = reg_write_in && reg_addr_in == 16'h4134;
   wire rd_dyn = reg_read_in && !reg_write_in && reg_addr_in == 16'h4134;
   // ----------------------------------------
   // helper state: otp lock and cycles since release
   // ----------------------------------------
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         otp_seen_reg <= 1'b0;
         rel_cnt_reg <= 4'h0;
      end else begin
         if (otp_load_in) otp_seen_reg <= 1'b1;
         if (rel_cnt_reg != 4'hf) rel_cnt_reg <= rel_cnt_reg + 4'h1;
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   // run state is entered at the eleventh edge after release
   AST_DONE_TIME: assert property (config_done_out == (rel_cnt_reg >= 4'hb))
      else $error("config done at wrong cycle");
   // polarity is the strap value that stood when the indicator was computed
   AST_IND: assert property (config_done_out |-> upstream_speed_indicator_out ==
      $past((config_done_out && upstream_connected_in && upstream_high_speed_in) ^ config_method_out[1]))
      else $error("speed indicator wrong");
   AST_PWR1_CAUSE: assert property (port1_power_enable_out |->
      $past(port1_power_request_in && !combined_control_mode_in)) else $error("port1 power without request");
   AST_PWR2_CAUSE: assert property (port2_power_enable_out |->
      $past(port2_power_request_in && !combined_control_mode_in)) else $error("port2 power without request");
   AST_DED_RELEASE: assert property ((!combined_control_mode_in)[*2] |->
      port1_combined_control_pin_oe_n_out && !port1_combined_control_pin_out) else $error("pin driven in dedicated");
   AST_COMB_OFF: assert property ((combined_control_mode_in && !port2_power_request_in)[*3] |->
      !port2_combined_control_pin_oe_n_out) else $error("port2 pin not pulled low");
   AST_STRAP_HOLD: assert property (config_done_out && $past(config_done_out) |->
      $stable(config_method_out) && $stable(port1_charging_enable_out)) else $error("strap latch moved");
   AST_OC_OFF: assert property (port1_overcurrent_out |-> !port1_power_enable_out)
      else $error("power on during fault");
   AST_OC_CAUSE: assert property ($rose(port1_overcurrent_out) |-> $past(fault1, 3))
      else $error("fault flag without cause");
   AST_RDATA_HOLD: assert property (!$past(reg_read_in) |-> $stable(reg_rdata_out))
      else $error("read data moved");
   AST_DYN_RDBACK: assert property ((wr_dyn && !otp_seen_reg && !otp_load_in) ##1
      (!reg_write_in && !otp_load_in) ##1 rd_dyn |=> reg_rdata_out == $past(reg_wdata_in, 3))
      else $error("dynamic register readback");
   COV_OC: cover property ($rose(port1_overcurrent_out));
   COV_IND: cover property ($rose(upstream_speed_indicator_out));
   COV_RD: cover property (rd_dyn);
endmodule

bind hpc_top hpc_chk hpc_chk_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .port1_overcurrent_low_in(port1_overcurrent_low_in), .port1_combined_control_pin_in(port1_combined_control_pin_in),
   .port1_combined_control_pin_out(port1_combined_control_pin_out),
   .port1_combined_control_pin_oe_n_out(port1_combined_control_pin_oe_n_out),
   .port2_combined_control_pin_oe_n_out(port2_combined_control_pin_oe_n_out),
   .upstream_connected_in(upstream_connected_in), .upstream_high_speed_in(upstream_high_speed_in),
   .combined_control_mode_in(combined_control_mode_in), .port1_power_request_in(port1_power_request_in),
   .port2_power_request_in(port2_power_request_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .otp_load_in(otp_load_in),
   .upstream_speed_indicator_out(upstream_speed_indicator_out), .port1_power_enable_out(port1_power_enable_out),
   .port2_power_enable_out(port2_power_enable_out), .port1_overcurrent_out(port1_overcurrent_out),
   .config_method_out(config_method_out), .port1_charging_enable_out(port1_charging_enable_out),
   .config_done_out(config_done_out));

// [testbench.sv]
// self-checking bench for hpc_top with the board power model.
// assumes straps are steady across each reset and its settle time.
`timescale 1ns/100ps

module testbench;
   logic mclk_in = 1'b0, rst_n_in = 1'b0, conn = 1'b0, hs = 1'b0, comb = 1'b0, spf = 1'b0;
   logic wr_en = 1'b0, rd_en = 1'b0, otp_ld = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00, otp_data = 8'h00;
   logic [6:0] strap = 7'h00;
   logic [1:0] req = 2'b00, fault = 2'b00;
   wire [1:0] en, oe_n, pin_d, ocl, pin, oc, cm, fixd;
   wire [7:0] rdata;
   wire ind, chg1, chg2, selfp, done;
   int bad_count = 0;
   int n_checks = 0;

   hpc_top hpc_top_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .config_method_strap_hi_in(strap[0]), .config_method_strap_lo_in(strap[1]),
      .port1_charging_strap_in(strap[2]), .port2_charging_strap_in(strap[3]),
      .fixed_device_straps_in(strap[5:4]), .self_power_detect_in(strap[6]),
      .port1_overcurrent_low_in(ocl[0]), .port2_overcurrent_low_in(ocl[1]),
      .port1_combined_control_pin_in(pin[0]), .port1_combined_control_pin_out(pin_d[0]),
      .port1_combined_control_pin_oe_n_out(oe_n[0]), .port2_combined_control_pin_in(pin[1]),
      .port2_combined_control_pin_out(pin_d[1]), .port2_combined_control_pin_oe_n_out(oe_n[1]),
      .upstream_connected_in(conn), .upstream_high_speed_in(hs), .combined_control_mode_in(comb),
      .self_power_function_in(spf), .port1_power_request_in(req[0]), .port2_power_request_in(req[1]),
      .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .otp_load_in(otp_ld), .otp_data_in(otp_data), .upstream_speed_indicator_out(ind),
      .port1_power_enable_out(en[0]), .port2_power_enable_out(en[1]), .port1_overcurrent_out(oc[0]),
      .port2_overcurrent_out(oc[1]), .port1_charging_enable_out(chg1), .port2_charging_enable_out(chg2),
      .config_method_out(cm), .self_powered_out(selfp), .fixed_device_out(fixd), .config_done_out(done));

   hpc_power_partner hpc_power_partner_inst (.combined_in(comb), .fault_in(fault), .enable_in(en),
      .pin_data_in(pin_d), .pin_oe_n_in(oe_n), .overcurrent_low_out(ocl), .pin_level_out(pin));

   initial begin
      forever #50 mclk_in = ~mclk_in;
   end

   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   // the extra edge keeps a strobe from being raised again in the same step
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      wr_en = 1'b1; addr = a; wdata = d; tick(1);
      wr_en = 1'b0; tick(1);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      rd_en = 1'b1; addr = a; tick(1);
      rd_en = 1'b0; tick(1);
      chk(rdata, exp);
   endtask
   task automatic reset_with(input logic [6:0] s);
      rst_n_in = 1'b0; strap = s; tick(12);
      rst_n_in = 1'b1; tick(14);
   endtask
   task automatic port_run(input int p, input logic c);
      comb = c; req[p] = 1'b0; tick(3);
      chk(oe_n[p], c ? 8'h00 : 8'h01);
      chk(pin_d[p], 8'h00);
      req[p] = 1'b1; tick(2);
      chk(en[p], !c);
      chk(oe_n[p], 8'h01);
      tick(12); fault[p] = 1'b1; tick(5);
      chk(oc[p], 8'h01);
      chk(en[p], 8'h00);
      chk(oe_n[p], !c);
      fault[p] = 1'b0; req[p] = 1'b0; tick(3);
      chk(oc[p], 8'h00);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #(3000 * 100);
      bad_count++;
      test_done;
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      tick(1);
      reset_with(7'b1_01_0_1_1_0);
      chk(cm, 8'h01);
      chk(chg1, 8'h01);
      chk(chg2, 8'h00);
      chk(selfp, 8'h01);
      chk(done, 8'h01);
      rd(16'h4134, 8'hc1);
      rd(16'h4135, 8'h00);
      rd(16'h4000, 8'h00);
      conn = 1'b1; hs = 1'b1; tick(2);
      chk(ind, 8'h01);
      hs = 1'b0; tick(2);
      chk(ind, 8'h00);
      strap[6] = 1'b0; tick(6);
      chk(selfp, 8'h01);
      wr(16'h4134, 8'h41);
      rd(16'h4134, 8'h41);
      tick(4);
      chk(selfp, 8'h00);
      wr(16'h4134, 8'h40);
      strap[6] = 1'b1; tick(6);
      chk(selfp, 8'h00);
      spf = 1'b1; wr(16'h4135, 8'h02);
      chk(fixd, 8'h02);
      rd(16'h4135, 8'h02);
      spf = 1'b0; tick(1);
      chk(fixd, 8'h01);
      for (int i = 0; i < 4; i++) port_run(i % 2, i / 2);
      otp_data = 8'h41; otp_ld = 1'b1; tick(1);
      otp_ld = 1'b0; tick(1);
      rd(16'h4134, 8'h41);
      wr(16'h4134, 8'hc1);
      rd(16'h4134, 8'h41);
      hs = 1'b1;
      reset_with(7'b0_10_1_0_0_1);
      chk(cm, 8'h02);
      chk(chg1, 8'h00);
      chk(chg2, 8'h01);
      chk(selfp, 8'h00);
      rd(16'h4134, 8'hc1);
      chk(ind, 8'h00);
      hs = 1'b0; strap[0] = 1'b0; tick(5);
      chk(ind, 8'h01);
      chk(cm, 8'h02);
      test_done;
   end
endmodule
